// File: dv/power_stage_model.sv
// behavioural half-bridge stage: node slew, rail comparators and pin source
`timescale 1ns/100ps
`default_nettype none
module power_stage_model (
  input wire logic pclk,
  input wire logic hs_gate_en,
  input wire logic ls_gate_en,
  input wire logic src_on,
  input wire logic slew_ok,
  input wire logic [12:0] base_mv,
  input wire logic [12:0] dv_mv,
  output logic sw_near_high,
  output logic sw_near_low,
  output logic [12:0] pin_mv
);
  logic [1:0] node = 2'b01;
  logic last_hi = 1'b0;
  logic [3:0] slew = 4'h0;
  // node leaves its rail two cycles after the gates drop, reaches the far one later
  always @(posedge pclk) begin
    if (hs_gate_en || ls_gate_en) begin
      node <= hs_gate_en ? 2'b10 : 2'b01;
      last_hi <= hs_gate_en;
      slew <= 4'h0;
    end else begin
      if (slew != 4'hF)
        slew <= slew + 4'h1;
      if (slew == 4'h1)
        node <= 2'b00;
      // weak tank current: node hangs mid-way and never trips the comparator
      if (slew == 4'h3 && slew_ok)
        node <= last_hi ? 2'b01 : 2'b10;
    end
  end
  assign sw_near_high = node[1];
  assign sw_near_low = node[0];
  // source current raises the pin by the divider's Thevenin drop
  assign pin_mv = src_on ? base_mv + dv_mv : base_mv;
endmodule // power_stage_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the dead-time and overcurrent control
`include "dtoc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int SS = 200;
  localparam int RS = 300;
  localparam int HALF = 100;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, hs_gate_en, ls_gate_en, src_on, fast_at_max, fault_pull_en;
  logic osc_phase = 1'b0, reg_ok = 1'b0, ls_over_slow = 1'b0, sw_over_fast = 1'b0;
  logic ext_disable_n = 1'b1, slew_ok = 1'b1, sw_near_high, sw_near_low;
  logic [12:0] pin_mv, base_mv = 13'd2400, dv_mv = 13'd0;
  logic [2:0] slow_level_sel, fault_code;
  int err_count = 0, n_checks = 0, cyc = 0, oc = 0, n, g, k;
  int dvt[6] = '{1135, 835, 595, 405, 250, 125};
  int dtv[3] = '{2400, 3900, 1000};
  int flt[3] = '{300, 4200, 4800};
  always #12.5 pclk = ~pclk;
  deadtime_overcurrent_ctrl #(.SS_CYC(SS), .RESTART_CYC(RS), .OP_UP_CYC(1000)) u_deadtime_overcurrent_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_phase(osc_phase), .reg_ok(reg_ok), .sw_near_high(sw_near_high), .sw_near_low(sw_near_low),
    .ls_over_slow(ls_over_slow), .sw_over_fast(sw_over_fast), .ext_disable_n(ext_disable_n),
    .pin_mv(pin_mv), .hs_gate_en(hs_gate_en), .ls_gate_en(ls_gate_en), .src_on(src_on),
    .slow_level_sel(slow_level_sel), .fast_at_max(fast_at_max), .fault_pull_en(fault_pull_en),
    .fault_code(fault_code));
  power_stage_model u_power_stage_model (.pclk(pclk), .hs_gate_en(hs_gate_en), .ls_gate_en(ls_gate_en),
    .src_on(src_on), .slew_ok(slew_ok), .base_mv(base_mv), .dv_mv(dv_mv),
    .sw_near_high(sw_near_high), .sw_near_low(sw_near_low), .pin_mv(pin_mv));
  // expected maximum dead-time in clock cycles, period limit included
  function automatic int dt_exp(input int v);
    int ns;
    ns = 150000 / (v - `V_OFS_MV);
    ns = ns < `DT_MIN_NS ? `DT_MIN_NS : (ns > `MAX_DEAD_TIME_NS ? `MAX_DEAD_TIME_NS : ns);
    return (ns / `CLK_NS) < (HALF / 4) ? ns / `CLK_NS : HALF / 4;
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return src_on;
      1: return fast_at_max;
      2: return fault_pull_en;
      default: return hs_gate_en;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wt(input int w, input logic v, input int lim, output int c);
    c = 0;
    while (sig(w) !== v && c < lim) begin
      @(posedge pclk);
      c++;
    end
    chk(sig(w), v);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // gap from high-side off to low-side on
  task automatic gap(output int c);
    wt(3, 1'b1, 300, c);
    wt(3, 1'b0, 300, c);
    c = 0;
    while (ls_gate_en !== 1'b1 && c < 300) begin
      @(posedge pclk);
      c++;
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (oc == HALF - 1) begin
      oc <= 0;
      osc_phase <= ~osc_phase;
    end else begin
      oc <= oc + 1;
    end
  end
  always @(negedge pclk) begin
    if (hs_gate_en && ls_gate_en)
      chk(1, 0);
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    k = $urandom(9);
    k = $urandom % 6;
    dv_mv = 13'(dvt[k]);
    repeat (8) @(posedge pclk);
    chk({slow_level_sel, fast_at_max, hs_gate_en, ls_gate_en, fault_pull_en}, 32'h68);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, `CTRL_RST);
    apb(1'b1, 8'h10, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    reg_ok <= 1'b1;
    wt(0, 1'b1, 20, n);
    wt(0, 1'b0, 2000, n);
    // source-off settle, then one edge to latch the level and one to show it
    repeat (`SETTLE_US * `CLK_MHZ + 3) @(posedge pclk);
    chk(src_on, 1'b0);
    chk(slow_level_sel, 3'(k + 1));
    chk(fast_at_max, 1'b1);
    wt(1, 1'b0, SS + 20, n);
    chk(n > SS - 10 && n < SS + 10, 1'b1);
    for (int i = 0; i < 3; i++) begin
      base_mv <= 13'(dtv[i]);
      repeat (6 * HALF) @(posedge pclk);
      apb(1'b0, `A_DTMAX, 32'h0);
      chk(rd, dt_exp(dtv[i]));
      slew_ok <= 1'b0;
      gap(g);
      chk(g >= dt_exp(dtv[i]) && g <= dt_exp(dtv[i]) + 4, 1'b1);
      slew_ok <= 1'b1;
      gap(g);
      chk(g < 10, 1'b1);
    end
    ext_disable_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(hs_gate_en | ls_gate_en, 1'b0);
    ext_disable_n <= 1'b1;
    apb(1'b1, `A_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk(hs_gate_en | ls_gate_en, 1'b0);
    apb(1'b1, `A_CTRL, 32'h1);
    sw_over_fast <= 1'b1;
    repeat (1 + $urandom % 3) @(posedge pclk);
    sw_over_fast <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(fault_pull_en, 1'b0);
    sw_over_fast <= 1'b1;
    wt(2, 1'b1, 20, n);
    chk(fault_code, `FC_FAST);
    sw_over_fast <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wt(2, 1'b0, RS + 20, n);
      chk(n > RS - 10 && n < RS + 10, 1'b1);
      wt(1, 1'b0, SS + 20, n);
      if (i < 3) begin
        base_mv <= 13'(flt[i]);
        wt(2, 1'b1, 40, n);
        chk(fault_code, 3'(i + 1));
        chk(hs_gate_en | ls_gate_en, 1'b0);
        base_mv <= 13'd2400;
      end
    end
    // high across a whole period, so one low-side phase is surely over the level
    ls_over_slow <= 1'b1;
    repeat (2 * HALF) @(posedge pclk);
    ls_over_slow <= 1'b0;
    // read only after the last over cycle has stopped counting up
    repeat (3 * HALF) @(posedge pclk);
    apb(1'b0, `A_OPCNT, 32'h0);
    g = rd;
    chk(g > 0, 1'b1);
    repeat (4 * HALF) @(posedge pclk);
    apb(1'b0, `A_OPCNT, 32'h0);
    chk(rd < g, 1'b1);
    ls_over_slow <= 1'b1;
    wt(2, 1'b1, 4000, n);
    chk(fault_code, `FC_SLOW);
    wt(2, 1'b0, RS + 20, n);
    wt(1, 1'b0, SS + 20, n);
    chk(fault_pull_en, 1'b0);
    ls_over_slow <= 1'b0;
    chk(src_on, 1'b0);
    summarize();
  end
endmodule // testbench
`default_nettype wire

// File: hw/deadtime_overcurrent_ctrl.sv
// half-bridge dead-time, pin decode and two-level overcurrent control with apb status
// Notes on behaviour
// - end dead-time when node reaches opposite rail
// - otherwise switch on when maximum expires
// - maximum is lesser of pin value, period/8
// - pin sets 150ns*1V/(V-0.9V), clamped 50ns-1.35us
// - pin below 0.5V is short fault
// - pin 3.95V-4.5V is out-of-range fault
// - pin above 4.5V is open fault
// - slow level only on low-side on-time
// - fast level trips after 100 ns above
// - soft-start: slow off, fast at 5A
// - after soft-start: slow programmed, fast five times
// - overpower counts up on cycles over 100ns
// - counts down on cycles never over 100ns
// - up 2.1ms to trip, down 180ms
// - wait 100 ms before restart
// - measure pin with source on and off
// - source stays off once setting latched
// - six levels from Thevenin resistance
// - full-scale slow threshold is 1 A
// - fault stops switching, pulls pin, reports code
// - soft-start lasts 1.5 ms
`include "dtoc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module deadtime_overcurrent_ctrl
  import dtoc_pkg::*;
#(
  parameter int SS_CYC = `SS_US * `CLK_MHZ,
  parameter int RESTART_CYC = `RESTART_MS * 1000 * `CLK_MHZ,
  parameter int OP_UP_CYC = `OP_UP_US * `CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_phase,
  input wire logic reg_ok,
  input wire logic sw_near_high,
  input wire logic sw_near_low,
  input wire logic ls_over_slow,
  input wire logic sw_over_fast,
  input wire logic ext_disable_n,
  input wire logic [12:0] pin_mv,
  output logic hs_gate_en,
  output logic ls_gate_en,
  output logic src_on,
  output logic [2:0] slow_level_sel,
  output logic fast_at_max,
  output logic fault_pull_en,
  output logic [2:0] fault_code
);
  localparam int FILT_CYC = (`FILT_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int SETTLE_CYC = `SETTLE_US * `CLK_MHZ;
  localparam logic [15:0] DT_MIN = 16'((`DT_MIN_NS + `CLK_NS - 1) / `CLK_NS);
  localparam logic [15:0] MAX_DEAD_TIME = 16'(`MAX_DEAD_TIME_NS / `CLK_NS);
  // up step / down step = 180 ms / 2.1 ms keeps both ramps exact
  localparam logic [31:0] OP_TRIP = 32'(OP_UP_CYC * `OP_UP_STEP);

  initial begin
    if (SS_CYC < 2 || RESTART_CYC < 2 || OP_UP_CYC < 1 || OP_UP_CYC > 7000000) begin
      $error("count parameter out of range");
    end
  end

  function automatic logic [15:0] dt_cycles(input logic [12:0] mv);
    logic [31:0] ns;
    ns = 32'(`MAX_DEAD_TIME_NS);
    if (mv > 13'(`V_OFS_MV)) begin
      ns = 32'(`DT_K_NSMV) / (32'(mv) - 32'(`V_OFS_MV));
    end
    if (ns > 32'(`MAX_DEAD_TIME_NS)) begin
      ns = 32'(`MAX_DEAD_TIME_NS);
    end
    if (ns < 32'(`DT_MIN_NS)) begin
      ns = 32'(`DT_MIN_NS);
    end
    dt_cycles = 16'(ns / 32'(`CLK_NS));
    if (dt_cycles < DT_MIN) begin
      dt_cycles = DT_MIN;
    end
  endfunction

  // 1 = one sixth of full scale ... 6 = full scale (1 A)
  function automatic logic [2:0] level_of(input logic [12:0] dv);
    if (dv >= 13'(`DV_L1_MV)) level_of = 3'h1;
    else if (dv >= 13'(`DV_L2_MV)) level_of = 3'h2;
    else if (dv >= 13'(`DV_L3_MV)) level_of = 3'h3;
    else if (dv >= 13'(`DV_L4_MV)) level_of = 3'h4;
    else if (dv >= 13'(`DV_L5_MV)) level_of = 3'h5;
    else level_of = 3'h6;
  endfunction

  // two-stage synchroniser; the adc word is assumed to be held steady between conversions
  logic [19:0] sync1_reg, sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 20'h0_0000;
      sync2_reg <= 20'h0_0000;
    end else begin
      sync1_reg <= {osc_phase, reg_ok, sw_near_high, sw_near_low, ls_over_slow, sw_over_fast,
                    ext_disable_n, pin_mv};
      sync2_reg <= sync1_reg;
    end
  end
  wire osc_s = sync2_reg[19];
  wire reg_ok_s = sync2_reg[18];
  wire near_hi_s = sync2_reg[17];
  wire near_lo_s = sync2_reg[16];
  wire slow_s = sync2_reg[15];
  wire fast_s = sync2_reg[14];
  wire ext_en_s = sync2_reg[13];
  wire [12:0] mv_s = sync2_reg[12:0];

  seq_t seq_reg;
  bridge_t br_reg;
  logic [31:0] ctrl_reg, tmr_reg, op_reg;
  logic [12:0] v_on_reg;
  logic [2:0] lvl_reg;
  logic [15:0] hp_cnt_reg, half_reg, dt_cnt_reg, prog_dt_reg;
  logic osc_d_reg, cyc_over_reg, op_up_reg;
  logic [2:0] slow_run_reg, fast_run_reg;

  // pin windows
  wire pin_short = mv_s < 13'(`V_SHORT_MV);
  wire pin_open = mv_s > 13'(`V_OPEN_MV);
  wire pin_oor = !pin_open && mv_s >= 13'(`V_OOR_MV);
  wire live = seq_reg == S_SOFT || seq_reg == S_RUN;
  wire [2:0] pin_fc = pin_short ? `FC_SHORT : pin_oor ? `FC_OOR : pin_open ? `FC_OPEN : `FC_NONE;
  wire fast_trip = fast_s && fast_run_reg == 3'(FILT_CYC - 1);
  wire op_trip = op_reg >= OP_TRIP;
  wire [2:0] fc_next = pin_fc != `FC_NONE ? pin_fc : fast_trip ? `FC_FAST : op_trip ? `FC_SLOW : `FC_NONE;
  wire go_fault = live && fc_next != `FC_NONE;
  wire sw_allow = live && ctrl_reg[`CTRL_EN_BIT] && ext_en_s;
  wire osc_edge = osc_s ^ osc_d_reg;
  wire [15:0] eighth = half_reg >> 2;
  wire [15:0] eff_dt = (eighth < prog_dt_reg) ? ((eighth < 16'h0001) ? 16'h0001 : eighth) : prog_dt_reg;
  wire dt_state = br_reg == B_DT_LS || br_reg == B_DT_HS;
  wire rail_hit = (br_reg == B_DT_LS && near_lo_s) || (br_reg == B_DT_HS && near_hi_s);
  wire dt_done = rail_hit || dt_cnt_reg + 16'h0001 >= eff_dt;
  wire tmr_done = tmr_reg == 32'h0000_0000;
  // slow level ignored outside run so soft-start cycles never feed the timer
  wire slow_hit = seq_reg == S_RUN && slow_run_reg == 3'(FILT_CYC);

  // start-up, soft-start, run and fault sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= S_WAIT;
      tmr_reg <= 32'h0000_0000;
      v_on_reg <= 13'h0000;
      lvl_reg <= 3'h6;
      fault_code <= `FC_NONE;
    end else begin
      if (!tmr_done) tmr_reg <= tmr_reg - 32'h0000_0001;
      case (seq_reg)
        S_WAIT: begin
          if (reg_ok_s) begin
            seq_reg <= S_SRC_ON;
            tmr_reg <= 32'(SETTLE_CYC);
          end
        end
        S_SRC_ON: begin
          if (tmr_done) begin
            v_on_reg <= mv_s;
            seq_reg <= S_SRC_OFF;
            tmr_reg <= 32'(SETTLE_CYC);
          end
        end
        S_SRC_OFF: begin
          if (tmr_done) begin
            lvl_reg <= level_of(v_on_reg > mv_s ? v_on_reg - mv_s : 13'h0000);
            seq_reg <= S_SOFT;
            tmr_reg <= 32'(SS_CYC);
          end
        end
        S_SOFT, S_RUN: begin
          if (go_fault) begin
            seq_reg <= S_FAULT;
            fault_code <= fc_next;
            tmr_reg <= 32'(RESTART_CYC - 1);
          end else if (seq_reg == S_SOFT && tmr_done) begin
            seq_reg <= S_RUN;
          end
        end
        S_FAULT: begin
          if (tmr_done) begin
            seq_reg <= S_SOFT;
            fault_code <= `FC_NONE;
            tmr_reg <= 32'(SS_CYC);
          end
        end
        default: seq_reg <= S_WAIT;
      endcase
    end
  end

  // half-period measurement and pin-programmed maximum dead-time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d_reg <= 1'b0;
      hp_cnt_reg <= 16'h0000;
      half_reg <= 16'hFFFF;
      prog_dt_reg <= DT_MIN;
    end else begin
      osc_d_reg <= osc_s;
      prog_dt_reg <= dt_cycles(mv_s);
      if (osc_edge) begin
        half_reg <= hp_cnt_reg + 16'h0001;
        hp_cnt_reg <= 16'h0000;
      end else if (hp_cnt_reg != 16'hFFFF) begin
        hp_cnt_reg <= hp_cnt_reg + 16'h0001;
      end
    end
  end

  // bridge sequencing with adaptive dead-time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      br_reg <= B_OFF;
      dt_cnt_reg <= 16'h0000;
    end else if (!sw_allow || go_fault) begin
      br_reg <= B_OFF;
      dt_cnt_reg <= 16'h0000;
    end else begin
      dt_cnt_reg <= dt_state ? dt_cnt_reg + 16'h0001 : 16'h0000;
      case (br_reg)
        B_OFF: if (osc_edge) br_reg <= B_HS;
        B_HS: if (osc_edge) br_reg <= B_DT_LS;
        B_LS: if (osc_edge) br_reg <= B_DT_HS;
        B_DT_LS: if (dt_done) br_reg <= B_LS;
        B_DT_HS: if (dt_done) br_reg <= B_HS;
        default: br_reg <= B_OFF;
      endcase
    end
  end

  // slow level per cycle, fast level filter, overpower up-down counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_run_reg <= 3'h0;
      fast_run_reg <= 3'h0;
      cyc_over_reg <= 1'b0;
      op_up_reg <= 1'b0;
      op_reg <= 32'h0000_0000;
    end else begin
      fast_run_reg <= (fast_s && live && fast_run_reg != 3'(FILT_CYC - 1)) ? fast_run_reg + 3'h1 : 3'h0;
      slow_run_reg <= (slow_s && br_reg == B_LS && slow_run_reg != 3'(FILT_CYC)) ? slow_run_reg + 3'h1 : 3'h0;
      if (br_reg == B_DT_HS && dt_done) begin
        // a hit in the closing cycle still counts for this switching cycle
        op_up_reg <= cyc_over_reg || slow_hit;
        cyc_over_reg <= 1'b0;
      end else if (slow_hit) begin
        cyc_over_reg <= 1'b1;
      end
      if (seq_reg != S_RUN) begin
        op_reg <= 32'h0000_0000;
        op_up_reg <= 1'b0;
        cyc_over_reg <= 1'b0;
      end else if (op_up_reg) begin
        op_reg <= op_reg + 32'(`OP_UP_STEP);
      end else if (op_reg >= 32'(`OP_DN_STEP)) begin
        op_reg <= op_reg - 32'(`OP_DN_STEP);
      end else begin
        op_reg <= 32'h0000_0000;
      end
    end
  end

  // registered drive outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_gate_en <= 1'b0;
      ls_gate_en <= 1'b0;
      src_on <= 1'b0;
      slow_level_sel <= 3'h6;
      fast_at_max <= 1'b1;
      fault_pull_en <= 1'b0;
    end else begin
      hs_gate_en <= br_reg == B_HS && sw_allow && !go_fault;
      ls_gate_en <= br_reg == B_LS && sw_allow && !go_fault;
      src_on <= seq_reg == S_WAIT && reg_ok_s || seq_reg == S_SRC_ON && !tmr_done;
      slow_level_sel <= lvl_reg;
      fast_at_max <= seq_reg != S_RUN;
      fault_pull_en <= seq_reg == S_FAULT || go_fault;
    end
  end

  // apb slave, zero wait states
  wire hit_ctrl = paddr == `A_CTRL;
  wire hit_stat = paddr == `A_STAT;
  wire hit_dt = paddr == `A_DTMAX;
  wire hit_op = paddr == `A_OPCNT;
  wire hit = hit_ctrl || hit_stat || hit_dt || hit_op;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg
                     : hit_stat ? {19'h0_0000, fault_pull_en, seq_reg, br_reg, lvl_reg, fault_code}
                     : hit_dt ? {16'h0000, eff_dt}
                     : hit_op ? op_reg : 32'h0000_0000;
  wire setup = psel && !penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup) prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      if (psel && penable && pready && pwrite && hit_ctrl) ctrl_reg <= pwdata;
    end
  end

  // checks
  sequence s_dt_ls_rail;
    br_reg == B_DT_LS && near_lo_s && sw_allow && !go_fault;
  endsequence
  property p_rail;
    @(posedge pclk) disable iff (!presetn)
      s_dt_ls_rail |=> br_reg == B_LS ##1 (ls_gate_en || $past(!sw_allow || go_fault));
  endproperty
  a_rail: assert property (p_rail) else $error("dead-time not ended at rail");
  property p_maxdt;
    @(posedge pclk) disable iff (!presetn) dt_state && $stable(eff_dt) |-> dt_cnt_reg < eff_dt;
  endproperty
  a_maxdt: assert property (p_maxdt) else $error("dead-time overran maximum");
  property p_clamp;
    @(posedge pclk) disable iff (!presetn) prog_dt_reg >= DT_MIN && prog_dt_reg <= MAX_DEAD_TIME;
  endproperty
  a_clamp: assert property (p_clamp) else $error("programmed dead-time out of clamp");
  property p_short;
    @(posedge pclk) disable iff (!presetn) live && pin_short |=> seq_reg == S_FAULT && fault_code == `FC_SHORT;
  endproperty
  a_short: assert property (p_short) else $error("pin short not faulted");
  property p_oor;
    @(posedge pclk) disable iff (!presetn) live && pin_oor |=> seq_reg == S_FAULT && fault_code == `FC_OOR;
  endproperty
  a_oor: assert property (p_oor) else $error("pin out of range not faulted");
  property p_open;
    @(posedge pclk) disable iff (!presetn) live && pin_open |=> seq_reg == S_FAULT && fault_code == `FC_OPEN;
  endproperty
  a_open: assert property (p_open) else $error("pin open not faulted");
  property p_fast;
    @(posedge pclk) disable iff (!presetn) (live && fast_s && pin_fc == `FC_NONE) [*4] |=> seq_reg == S_FAULT;
  endproperty
  a_fast: assert property (p_fast) else $error("fast level did not trip");
  property p_soft;
    @(posedge pclk) disable iff (!presetn) seq_reg == S_SOFT |=> fast_at_max && op_reg == 32'h0000_0000;
  endproperty
  a_soft: assert property (p_soft) else $error("soft-start thresholds wrong");
  property p_restart;
    @(posedge pclk) disable iff (!presetn) seq_reg == S_FAULT && !tmr_done |=> seq_reg == S_FAULT;
  endproperty
  a_restart: assert property (p_restart) else $error("restart before delay");
  property p_src;
    @(posedge pclk) disable iff (!presetn) $fell(seq_reg == S_SRC_OFF) |=> !src_on [*8];
  endproperty
  a_src: assert property (p_src) else $error("source on after latch");
  property p_stop;
    @(posedge pclk) disable iff (!presetn) fault_pull_en |-> !hs_gate_en && !ls_gate_en;
  endproperty
  a_stop: assert property (p_stop) else $error("switching during fault");
endmodule // deadtime_overcurrent_ctrl
`default_nettype wire

// File: shared/dtoc_params.svh
// timing, threshold, offset and reset constants for the dead-time and overcurrent control
`ifndef DTOC_PARAMS_SVH
`define DTOC_PARAMS_SVH
`define CLK_MHZ 40
`define CLK_NS 25
`define SS_US 1500
`define RESTART_MS 100
`define OP_UP_US 2100
`define OP_DN_MS 180
`define OP_UP_STEP 600
`define OP_DN_STEP 7
`define FILT_NS 100
`define SETTLE_US 20
`define DT_MIN_NS 50
`define MAX_DEAD_TIME_NS 1350
`define DT_K_NSMV 150000
`define V_OFS_MV 900
`define V_SHORT_MV 500
`define V_OOR_MV 3950
`define V_OPEN_MV 4500
`define DV_L1_MV 1000
`define DV_L2_MV 700
`define DV_L3_MV 500
`define DV_L4_MV 325
`define DV_L5_MV 185
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_DTMAX 8'h08
`define A_OPCNT 8'h0C
`define CTRL_EN_BIT 0
`define CTRL_RST 32'h0000_0001
`define FC_NONE 3'h0
`define FC_SHORT 3'h1
`define FC_OOR 3'h2
`define FC_OPEN 3'h3
`define FC_SLOW 3'h4
`define FC_FAST 3'h5
`endif

// File: shared/dtoc_pkg.sv
// state types of the dead-time and overcurrent control
package dtoc_pkg;
  typedef enum logic [2:0] {S_WAIT, S_SRC_ON, S_SRC_OFF, S_SOFT, S_RUN, S_FAULT} seq_t;
  typedef enum logic [2:0] {B_OFF, B_HS, B_DT_LS, B_LS, B_DT_HS} bridge_t;
endpackage
